// *** logic/printer_port_pkg.sv ***
/*
  Constants for the printer port with general-purpose pins: register
  offsets, field positions, values after reset and the host access states.
  Assumes a single clock domain; the host strobes are sampled on it.
*/
`default_nettype none

package printer_port_pkg;

  // register offsets on the two address lines {high, low}
  localparam logic [1:0] OFS_DATA    = 2'h0;
  localparam logic [1:0] OFS_STATUS  = 2'h1;
  localparam logic [1:0] OFS_CONTROL = 2'h2;
  localparam logic [1:0] OFS_GPIO    = 2'h3;

  // control register fields
  localparam int CTL_STROBE   = 0;
  localparam int CTL_AUTOFEED = 1;
  localparam int CTL_INIT     = 2;
  localparam int CTL_SELIN    = 3;
  localparam int CTL_IRQEN    = 4;
  localparam int CTL_DIR      = 5;
  localparam int CTL_STORED_W = 5;

  // status register fields
  localparam int ST_FLAG     = 2;
  localparam int ST_FAULT    = 3;
  localparam int ST_ONLINE   = 4;
  localparam int ST_MEDIA    = 5;
  localparam int ST_ACK      = 6;
  localparam int ST_OCCUPIED = 7;

  // general-purpose pin groups
  localparam int GP_BIDIR_LO = 3;
  localparam int GP_BIDIR_HI = 4;
  localparam int GP_OUT_LO   = 5;
  localparam int GP_OUT_HI   = 7;

  // constant bits seen on reads
  localparam logic [7:0] STATUS_ONES  = 8'h03;
  localparam logic [7:0] CONTROL_ONES = 8'he0;

  // values after reset
  localparam logic [7:0] DATA_RESET    = 8'h00;
  localparam logic [4:0] CONTROL_RESET = 5'h04;
  localparam logic       DIR_RESET     = 1'b0;
  localparam logic       FLAG_RESET    = 1'b1;
  localparam logic [7:0] GP_OUT_RESET  = 8'h00;
  localparam logic [7:0] HOST_RD_RESET = 8'h00;

  // host access phase; every step from idle changes one bit
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_READ  = 2'b01,
    ACC_WRITE = 2'b10
  } access_e;

endpackage

`default_nettype wire

// *** logic/general_pins_reg.sv ***
/*
  General-purpose pin register: three inputs, two bidirectional bits and
  three outputs. Assumes the host side hands it a one-cycle write pulse
  and reads its value combinationally.
*/
`timescale 1ns/1ps
`default_nettype none

module general_pins_reg
  import printer_port_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // host side
  input  wire logic       write_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [1:0] bidir_out_i,
  output logic      [7:0] rdata_o,
  // pins
  input  wire logic [7:0] pins_i,
  output logic      [7:0] pins_o,
  output logic      [7:0] pins_oe_n_o
);

  logic [7:0] out_mask;

  // bits 0..2 never drive; bits 3,4 drive when configured as outputs
  assign out_mask = {3'b111, bidir_out_i, 3'b000};

  // input bits are never written
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_o <= GP_OUT_RESET;
    end else if (write_i) begin
      pins_o[GP_OUT_HI:GP_BIDIR_LO] <= wdata_i[GP_OUT_HI:GP_BIDIR_LO];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pins_oe_n_o <= 8'hff;
    end else begin
      pins_oe_n_o <= ~out_mask;
    end
  end

  // output bits return the latch, input bits the pin
  assign rdata_o = (pins_o & out_mask) | (pins_i & ~out_mask);

endmodule

`default_nettype wire

// *** logic/printer_port.sv ***
/*
  Parallel printer port with a general-purpose pin register, reached by
  host read and write strobes, a port select and two address lines.
  Assumes all host and printer inputs are synchronous to clock_i and that
  a strobe stays low for at least two clock cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module printer_port
  import printer_port_pkg::*;
(
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // host strobe interface
  input  wire logic       printer_port_select_n_i,
  input  wire logic       host_read_strobe_n_i,
  input  wire logic       host_write_strobe_n_i,
  input  wire logic       addr_bit_low_i,
  input  wire logic       addr_bit_high_i,
  input  wire logic [7:0] host_data_i,
  output logic      [7:0] host_data_o,
  output logic            host_data_oe_n_o,
  output logic            ack_irq_o,
  // mode and configuration pins
  input  wire logic       enhancement_pin_n_i,
  input  wire logic       gp_enable_i,
  input  wire logic [1:0] gp_bidir_out_i,
  // printer data and control
  input  wire logic [7:0] printer_bus_lines_i,
  output logic      [7:0] printer_bus_lines_o,
  output logic            printer_bus_lines_oe_n_o,
  output logic            strobe_ctl_n_o,
  output logic            auto_feed_ctl_n_o,
  output logic            init_n_o,
  output logic            select_input_ctl_n_o,
  // printer status
  input  wire logic       fault_n_i,
  input  wire logic       online_status_i,
  input  wire logic       media_out_status_i,
  input  wire logic       ack_n_i,
  input  wire logic       printer_occupied_i,
  // general-purpose pins
  input  wire logic [7:0] gp_pins_i,
  output logic      [7:0] gp_pins_o,
  output logic      [7:0] gp_pins_oe_n_o
);

  function automatic logic at(input logic [1:0] addr,
                              input logic [1:0] ofs);
    at = (addr == ofs);
  endfunction

  access_e    access;
  access_e    next_access;
  logic [1:0] addr;
  logic       rd_req;
  logic       wr_req;
  logic       read_start;
  logic       write_start;
  logic       read_valid;
  logic [4:0] ctl_stored;
  logic       dir;
  logic       ack_irq_flag_n;
  logic       ack_prev_n;
  logic       ack_release;
  logic       extended;
  logic       drive_bus;
  logic [7:0] printer_status_reg;
  logic [7:0] printer_control_reg;
  logic [7:0] gp_rdata;
  logic [7:0] read_value;

  assign addr     = {addr_bit_high_i, addr_bit_low_i};
  assign extended = enhancement_pin_n_i;

  // a strobe counts only with the port selected and the other strobe high
  assign rd_req = ~printer_port_select_n_i & ~host_read_strobe_n_i
                  & host_write_strobe_n_i;
  assign wr_req = ~printer_port_select_n_i & ~host_write_strobe_n_i
                  & host_read_strobe_n_i;

  // one access per strobe: side effects fire only on entry
  always_comb begin
    next_access = access;
    case (access)
      ACC_IDLE: begin
        if (rd_req) begin
          next_access = ACC_READ;
        end else if (wr_req) begin
          next_access = ACC_WRITE;
        end
      end
      ACC_READ: begin
        if (!rd_req) begin
          next_access = ACC_IDLE;
        end
      end
      ACC_WRITE: begin
        if (!wr_req) begin
          next_access = ACC_IDLE;
        end
      end
      default: begin
        next_access = ACC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      access <= ACC_IDLE;
    end else begin
      access <= next_access;
    end
  end

  assign read_start  = (access == ACC_IDLE) & rd_req;
  assign write_start = (access == ACC_IDLE) & wr_req & ~rd_req;

  // data latch drives the lines directly
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      printer_bus_lines_o <= DATA_RESET;
    end else if (write_start && at(addr, OFS_DATA)) begin
      printer_bus_lines_o <= host_data_i;
    end
  end

  // compatibility mode drives always; extended only with direction low
  assign drive_bus = ~extended | ~dir;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      printer_bus_lines_oe_n_o <= 1'b0;
    end else begin
      printer_bus_lines_oe_n_o <= ~drive_bus;
    end
  end

  // control register and its printer outputs
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_stored           <= CONTROL_RESET;
      dir                  <= DIR_RESET;
      strobe_ctl_n_o       <= ~CONTROL_RESET[CTL_STROBE];
      auto_feed_ctl_n_o    <= ~CONTROL_RESET[CTL_AUTOFEED];
      init_n_o             <= CONTROL_RESET[CTL_INIT];
      select_input_ctl_n_o <= ~CONTROL_RESET[CTL_SELIN];
    end else if (write_start && at(addr, OFS_CONTROL)) begin
      ctl_stored           <= host_data_i[CTL_STORED_W-1:0];
      dir                  <= host_data_i[CTL_DIR];
      strobe_ctl_n_o       <= ~host_data_i[CTL_STROBE];
      auto_feed_ctl_n_o    <= ~host_data_i[CTL_AUTOFEED];
      init_n_o             <= host_data_i[CTL_INIT];
      select_input_ctl_n_o <= ~host_data_i[CTL_SELIN];
    end
  end

  // acknowledge release detector
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_prev_n <= 1'b1;
    end else begin
      ack_prev_n <= ack_n_i;
    end
  end

  assign ack_release = ~ack_prev_n & ack_n_i;

  // with the interrupt enabled, a release in the same cycle as a status read wins over the read
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_irq_flag_n <= FLAG_RESET;
    end else if (ack_release && ctl_stored[CTL_IRQEN]) begin
      ack_irq_flag_n <= 1'b0;
    end else if (read_start && at(addr, OFS_STATUS)) begin
      ack_irq_flag_n <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ack_irq_o <= 1'b0;
    end else begin
      ack_irq_o <= ctl_stored[CTL_IRQEN] & ~ack_irq_flag_n;
    end
  end

  always_comb begin
    printer_status_reg              = STATUS_ONES;
    printer_status_reg[ST_FLAG]     = ack_irq_flag_n;
    printer_status_reg[ST_FAULT]    = fault_n_i;
    printer_status_reg[ST_ONLINE]   = online_status_i;
    printer_status_reg[ST_MEDIA]    = media_out_status_i;
    printer_status_reg[ST_ACK]      = ack_n_i;
    printer_status_reg[ST_OCCUPIED] = printer_occupied_i;
  end

  assign printer_control_reg = CONTROL_ONES | {3'b000, ctl_stored};

  general_pins_reg u_gp (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .write_i     (write_start && at(addr, OFS_GPIO) && gp_enable_i),
    .wdata_i     (host_data_i),
    .bidir_out_i (gp_bidir_out_i),
    .rdata_o     (gp_rdata),
    .pins_i      (gp_pins_i),
    .pins_o      (gp_pins_o),
    .pins_oe_n_o (gp_pins_oe_n_o)
  );

  // read decode; address 3 answers only with the pins enabled
  always_comb begin
    read_value = 8'h00;
    read_valid = 1'b1;
    case (addr)
      OFS_DATA: begin
        read_value = (extended && dir) ? printer_bus_lines_i
                                       : printer_bus_lines_o;
      end
      OFS_STATUS: begin
        read_value = printer_status_reg;
      end
      OFS_CONTROL: begin
        read_value = printer_control_reg;
      end
      OFS_GPIO: begin
        read_value = gp_rdata;
        read_valid = gp_enable_i;
      end
      default: begin
        read_valid = 1'b0;
      end
    endcase
  end

  // host data follows the register while the read strobe lasts
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      host_data_o      <= HOST_RD_RESET;
      host_data_oe_n_o <= 1'b1;
    end else begin
      host_data_o      <= (rd_req && read_valid) ? read_value
                                                 : HOST_RD_RESET;
      host_data_oe_n_o <= ~(rd_req && read_valid);
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_no_drive_unsel: assert property (
    printer_port_select_n_i |=> host_data_oe_n_o)
    else $error("host data driven while port deselected");

  a_status_ones: assert property (
    rd_req && at(addr, OFS_STATUS)
    |=> !host_data_oe_n_o && host_data_o[1:0] == 2'b11)
    else $error("status low bits not one");

  a_status_mirror: assert property (
    rd_req && at(addr, OFS_STATUS)
    |=> host_data_o[7:3] == $past({printer_occupied_i, ack_n_i,
        media_out_status_i, online_status_i, fault_n_i}))
    else $error("status bits do not follow printer inputs");

  a_flag_clear: assert property (
    !ack_n_i ##1 ack_n_i && ctl_stored[CTL_IRQEN] |=> !ack_irq_flag_n)
    else $error("acknowledge release did not clear flag");

  a_flag_restore: assert property (
    read_start && at(addr, OFS_STATUS) && !ack_release
    |=> ack_irq_flag_n)
    else $error("status read did not restore flag");

  a_compat_drive: assert property (
    !extended [*2] |-> !printer_bus_lines_oe_n_o)
    else $error("data lines not driven in compatibility mode");

  a_data_write: assert property (
    write_start && at(addr, OFS_DATA)
    |=> printer_bus_lines_o == $past(host_data_i))
    else $error("data write not on lines");

  a_ext_read_live: assert property (
    rd_req && at(addr, OFS_DATA) && extended && dir
    |=> host_data_o == $past(printer_bus_lines_i))
    else $error("extended read did not return live lines");

  a_dir_release: assert property (
    extended && dir [*2] |-> printer_bus_lines_oe_n_o)
    else $error("lines driven with direction set to input");

  a_ctl_readback: assert property (
    rd_req && at(addr, OFS_CONTROL)
    |=> host_data_o == {CONTROL_ONES[7:5], $past(ctl_stored[CTL_IRQEN]),
        !$past(select_input_ctl_n_o), $past(init_n_o),
        !$past(auto_feed_ctl_n_o), !$past(strobe_ctl_n_o)})
    else $error("control read back wrong");

  a_ctl_outputs: assert property (
    write_start && at(addr, OFS_CONTROL)
    |=> strobe_ctl_n_o == !$past(host_data_i[0])
        && auto_feed_ctl_n_o == !$past(host_data_i[1])
        && init_n_o == $past(host_data_i[2])
        && select_input_ctl_n_o == !$past(host_data_i[3]))
    else $error("control outputs do not follow written bits");

  a_irq_output: assert property (
    ##1 ack_irq_o == $past(ctl_stored[CTL_IRQEN] & ~ack_irq_flag_n))
    else $error("interrupt output does not follow flag and enable");

  a_gp_inputs: assert property (
    gp_pins_oe_n_o[2:0] == 3'b111)
    else $error("general input bits driven");

  c_ack_irq: cover property (ack_release && ctl_stored[CTL_IRQEN]);
  c_status_rd: cover property (read_start && at(addr, OFS_STATUS));
  c_ext_input: cover property (rd_req && extended && dir);
  c_gp_write: cover property (write_start && at(addr, OFS_GPIO)
                              && gp_enable_i);

endmodule

`default_nettype wire

// *** testbench/printer_model.sv ***
/*
  Printer model: answers each strobe with a one-cycle acknowledge and
  drives the data lines with a scenario value.
  Assumes the port's clock and reset; the bench merges the line drivers.
*/
`timescale 1ns/1ps
`default_nettype none

module printer_model (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // port side
  input  wire logic       strobe_ctl_n_i,
  input  wire logic [7:0] drive_i,
  // printer side
  output logic      [7:0] lines_o,
  output logic            ack_n_o
);
  logic       strobe_q;
  logic [2:0] wait_q;

  assign lines_o = drive_i;

  // acknowledge pulse a few cycles after the strobe is asserted
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_q <= 1'b1;
      wait_q   <= 3'h0;
      ack_n_o  <= 1'b1;
    end else begin
      strobe_q <= strobe_ctl_n_i;
      ack_n_o  <= !(wait_q == 3'h1);
      if (strobe_q && !strobe_ctl_n_i) begin
        wait_q <= 3'h3;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
/*
  Testbench for the printer port: host strobe accesses with expected
  values. Assumes the port takes a strobe held low for two clock cycles
  and wants one idle cycle between strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import printer_port_pkg::*;
  logic       clock_i = 0, rst_i = 1;
  logic       sel_n = 1, rd_n = 1, wr_n = 1, a0 = 0, a1 = 0;
  logic       enh_n = 0, gp_en = 0;
  logic [1:0] gp_dir = 2'h0;
  logic [7:0] hd = 8'h00, pdrive = 8'h96, gp_in = 8'h05;
  logic [3:0] st = 4'h7;
  logic [7:0] hq, lines_o, gp_o, gp_oe_n, mdrv, q;
  logic       hoe_n, irq, lines_oe_n, stb_n, afd_n, init_n, select_input_ctl_n;
  logic       ack_n, o;
  int         bad_count = 0, samples_checked = 0;
  wire logic [7:0] lines = lines_oe_n ? mdrv : lines_o;
  wire logic [7:0] gp = (gp_oe_n & gp_in) | (~gp_oe_n & gp_o);

  printer_port printer_port_i (
    .clock_i(clock_i), .rst_i(rst_i),
    .printer_port_select_n_i(sel_n), .host_read_strobe_n_i(rd_n),
    .host_write_strobe_n_i(wr_n), .addr_bit_low_i(a0),
    .addr_bit_high_i(a1), .host_data_i(hd), .host_data_o(hq),
    .host_data_oe_n_o(hoe_n), .ack_irq_o(irq),
    .enhancement_pin_n_i(enh_n), .gp_enable_i(gp_en),
    .gp_bidir_out_i(gp_dir), .printer_bus_lines_i(lines),
    .printer_bus_lines_o(lines_o),
    .printer_bus_lines_oe_n_o(lines_oe_n), .strobe_ctl_n_o(stb_n),
    .auto_feed_ctl_n_o(afd_n), .init_n_o(init_n),
    .select_input_ctl_n_o(select_input_ctl_n), .fault_n_i(st[0]),
    .online_status_i(st[1]), .media_out_status_i(st[2]),
    .ack_n_i(ack_n), .printer_occupied_i(st[3]),
    .gp_pins_i(gp), .gp_pins_o(gp_o), .gp_pins_oe_n_o(gp_oe_n));

  printer_model printer_model_i (
    .clock_i(clock_i), .rst_i(rst_i), .strobe_ctl_n_i(stb_n),
    .drive_i(pdrive), .lines_o(mdrv), .ack_n_o(ack_n));

  initial begin
    forever #4 clock_i = !clock_i;
  end

  task automatic final_report;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  // one strobe: two cycles low, then one idle cycle
  task automatic acc(logic s, logic w, logic [1:0] a, logic [7:0] d);
    @(posedge clock_i); #1;
    sel_n = s; rd_n = w; wr_n = !w; {a1, a0} = a; hd = d;
    @(posedge clock_i); #1;
    q = hq; o = hoe_n;
    @(posedge clock_i); #1;
    sel_n = 1; rd_n = 1; wr_n = 1;
    @(posedge clock_i); #1;
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    acc(1'b0, 1'b1, a, d);
  endtask

  task automatic rd(logic [1:0] a, logic [7:0] e);
    acc(1'b0, 1'b0, a, 8'h00);
    chk("read data", e, q);
    chk("read enable", 8'h00, {7'h0, o});
  endtask

  task automatic pins(logic [3:0] e);
    chk("control pins", {4'h0, e}, {4'h0, select_input_ctl_n, init_n, afd_n, stb_n});
  endtask

  logic [7:0] vals [7] = '{8'h01, 8'h02, 8'h00, 8'h08, 8'h10, 8'h3f,
                           8'h04};

  initial begin
    repeat (2) @(posedge clock_i);
    #1 rst_i = 0;
    pins(4'hf);
    chk("irq", 8'h00, {7'h0, irq});
    rd(OFS_CONTROL, 8'he4);
    rd(OFS_STATUS, 8'h7f);
    st = 4'h8;
    rd(OFS_STATUS, 8'hc7);
    st = 4'h7;
    acc(1'b1, 1'b0, OFS_STATUS, 8'h00);
    chk("deselected read", 8'h01, {7'h0, o});
    chk("deselected data", 8'h00, q);
    acc(1'b1, 1'b1, OFS_CONTROL, 8'h00);
    pins(4'hf);
    foreach (vals[i]) begin
      wr(OFS_CONTROL, vals[i]);
      pins({~vals[i][3], vals[i][2], ~vals[i][1], ~vals[i][0]});
      rd(OFS_CONTROL, CONTROL_ONES | vals[i]);
    end
    acc(1'b0, 1'b0, OFS_STATUS, 8'h00);
    wr(OFS_CONTROL, 8'h14);
    wr(OFS_CONTROL, 8'h15);
    for (int i = 0; i < 20 && irq !== 1'b1; i++) @(posedge clock_i);
    #1 chk("irq", 8'h01, {7'h0, irq});
    if (irq !== 1'b1) final_report;
    rd(OFS_STATUS, 8'h7b);
    chk("irq", 8'h00, {7'h0, irq});
    rd(OFS_STATUS, 8'h7f);
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_CONTROL, 8'h05);
    repeat (10) @(posedge clock_i);
    #1 chk("irq", 8'h00, {7'h0, irq});
    rd(OFS_STATUS, 8'h7f);
    wr(OFS_DATA, 8'ha5);
    chk("lines", 8'ha5, lines_o);
    wr(OFS_CONTROL, 8'h24);
    chk("lines drive", 8'h00, {7'h0, lines_oe_n});
    rd(OFS_DATA, 8'ha5);
    wr(OFS_CONTROL, 8'h04);
    wr(OFS_STATUS, 8'h00);
    wr(OFS_GPIO, 8'hff);
    chk("gp out", 8'h00, gp_o);
    acc(1'b0, 1'b0, OFS_GPIO, 8'h00);
    chk("gp read off", 8'h01, {7'h0, o});
    rd(OFS_CONTROL, 8'he4);
    enh_n = 1;
    rd(OFS_DATA, 8'ha5);
    wr(OFS_CONTROL, 8'h24);
    chk("lines drive", 8'h01, {7'h0, lines_oe_n});
    rd(OFS_DATA, 8'h96);
    wr(OFS_DATA, 8'h5a);
    chk("lines", 8'h5a, lines_o);
    rd(OFS_DATA, 8'h96);
    wr(OFS_CONTROL, 8'h04);
    chk("lines drive", 8'h00, {7'h0, lines_oe_n});
    rd(OFS_DATA, 8'h5a);
    gp_en = 1;
    gp_dir = 2'h1;
    wr(OFS_GPIO, 8'hff);
    chk("gp drive", 8'h17, gp_oe_n);
    chk("gp out", 8'hf8, gp_o);
    rd(OFS_GPIO, 8'hed);
    wr(OFS_GPIO, 8'h00);
    rd(OFS_GPIO, 8'h05);
    gp_dir = 2'h2;
    wr(OFS_GPIO, 8'h18);
    chk("gp drive", 8'h0f, gp_oe_n);
    chk("gp out", 8'h18, gp_o);
    rd(OFS_GPIO, 8'h15);
    final_report;
  end
endmodule

`default_nettype wire
